// file: rtl/pcs_pkg.sv
package pcs_pkg;
    localparam int PC_W = 15;
    localparam int SP_W = 5;
    localparam logic [4:0] SP_EMPTY = 5'h1F;
    localparam logic [4:0] SP_LAST = 5'h0F;
    // Register offsets on the plain register port
    localparam logic [3:0] REG_PC_LOW = 4'h0;
    localparam logic [3:0] REG_PC_LATCH = 4'h1;
    localparam logic [3:0] REG_STACK_PTR = 4'h2;
    localparam logic [3:0] REG_TOS_LOW = 4'h3;
    localparam logic [3:0] REG_TOS_HIGH = 4'h4;
    localparam logic [3:0] REG_PTR0_LOW = 4'h5;
    localparam logic [3:0] REG_PTR0_HIGH = 4'h6;
    localparam logic [3:0] REG_PTR1_LOW = 4'h7;
    localparam logic [3:0] REG_PTR1_HIGH = 4'h8;
    localparam logic [3:0] REG_RESET_STATUS = 4'h9;
    // Reset status field positions
    localparam int RST_UNF_BIT = 0;
    localparam int RST_OVF_BIT = 1;
    // Indirect address map
    localparam logic [15:0] TRAD_END = 16'h0FFF;
    localparam logic [15:0] LIN_BASE = 16'h2000;
    localparam logic [15:0] LIN_END = 16'h29AF;
    localparam logic [7:0] GPR_BLOCK = 8'h50;
    localparam logic [6:0] GPR_FIRST = 7'h20;
    localparam logic [6:0] INDIR0_ADDR = 7'h00;
    localparam logic [6:0] INDIR1_ADDR = 7'h01;

    typedef enum logic [2:0] {
        PCS_OP_NONE, PCS_OP_CALL, PCS_OP_COMPUTED_CALL, PCS_OP_REG_BRANCH,
        PCS_OP_IMM_BRANCH, PCS_OP_INT, PCS_OP_RET
    } pcs_op_e;

    typedef struct packed {
        pcs_op_e op;
        logic [10:0] operand;
        logic [7:0] wreg;
        logic [14:0] vector;
    } pcs_ctl_s;

    typedef struct packed {
        logic valid;
        logic sel;
        logic write;
        logic [7:0] wdata;
    } pcs_ind_s;

    typedef struct packed {
        logic valid;
        logic flash;
        logic [14:0] addr;
        logic write;
        logic [7:0] wdata;
    } pcs_mem_s;
endpackage

// file: rtl/pcs_core.sv
`timescale 1ns/1ns
`default_nettype none
module pcs_core #(
    parameter int STACK_DEPTH = 16,
    parameter int LIN_BANKS = 32
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Configuration
    input wire logic stack_fault_reset_enable,
    // Execution unit events
    input wire pcs_pkg::pcs_ctl_s ctl,
    input wire pcs_pkg::pcs_ind_s ind,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Program counter
    output logic [14:0] pc,
    output logic fetch_flush,
    output logic stack_reset,
    // Indirect memory access
    output pcs_pkg::pcs_mem_s mem,
    input wire logic [7:0] mem_rdata,
    input wire logic [7:0] flash_rdata,
    output logic [7:0] ind_rdata,
    output logic ind_done
);
    // Stack array and bank field are sized for these ranges only
    if (STACK_DEPTH != 16 || LIN_BANKS < 1 || LIN_BANKS > 32) begin : g_bad_params
        $error("pcs_core: unsupported parameters");
    end

    // ----------------------------------------
    // Program counter
    // ----------------------------------------
    logic [14:0] pc_q;
    logic [6:0] pc_high_latch_q;
    logic [4:0] stack_pointer_reg_q;
    logic [14:0] stack_mem [0:15];
    logic stack_overflow_flag_q, stack_underflow_flag_q;
    logic flush_q;
    logic [14:0] pc_inc;
    logic [14:0] tos;
    logic push, pop, pc_wr, ovf, unf;

    assign pc_inc = pc_q + 15'h0001;
    assign tos = stack_mem[stack_pointer_reg_q[3:0]];
    assign push = ctl.op == pcs_pkg::PCS_OP_CALL || ctl.op == pcs_pkg::PCS_OP_COMPUTED_CALL
        || ctl.op == pcs_pkg::PCS_OP_INT;
    assign pop = ctl.op == pcs_pkg::PCS_OP_RET;
    assign pc_wr = reg_wr && reg_addr == pcs_pkg::REG_PC_LOW;
    assign ovf = push && stack_pointer_reg_q == pcs_pkg::SP_LAST;
    assign unf = pop && stack_pointer_reg_q == pcs_pkg::SP_EMPTY;
    assign stack_reset = stack_fault_reset_enable && (ovf || unf);

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pc_q <= 15'h0000;
        end else if (stack_reset) begin
            pc_q <= 15'h0000;
        end else if (pc_wr) begin
            pc_q <= {pc_high_latch_q, reg_wdata};
        end else begin
            unique case (ctl.op)
                pcs_pkg::PCS_OP_CALL: pc_q <= {pc_high_latch_q[6:3], ctl.operand};
                pcs_pkg::PCS_OP_COMPUTED_CALL: pc_q <= {pc_high_latch_q, ctl.wreg};
                pcs_pkg::PCS_OP_REG_BRANCH: pc_q <= pc_inc + {7'h00, ctl.wreg};
                pcs_pkg::PCS_OP_IMM_BRANCH: pc_q <= pc_inc + {{6{ctl.operand[8]}}, ctl.operand[8:0]};
                pcs_pkg::PCS_OP_INT: pc_q <= ctl.vector;
                pcs_pkg::PCS_OP_RET: pc_q <= tos;
                pcs_pkg::PCS_OP_NONE: pc_q <= pc_q;
                // Unused op code is ignored rather than trusted
                default: pc_q <= pc_q;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            flush_q <= 1'b0;
        end else begin
            flush_q <= pc_wr || (ctl.op != pcs_pkg::PCS_OP_NONE && ctl.op != pcs_pkg::PCS_OP_INT);
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pc_high_latch_q <= 7'h00;
        end else if (reg_wr && reg_addr == pcs_pkg::REG_PC_LATCH) begin
            pc_high_latch_q <= reg_wdata[6:0]; // Untouched by push and pop
        end
    end

    // ----------------------------------------
    // Return stack
    // ----------------------------------------
    // Pointer wraps through 0x0F to 0x00 when fault reset is off
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            stack_pointer_reg_q <= pcs_pkg::SP_EMPTY;
        end else if (stack_reset) begin
            stack_pointer_reg_q <= pcs_pkg::SP_EMPTY;
        end else if (push) begin
            stack_pointer_reg_q <= ovf ? 5'h00 : stack_pointer_reg_q + 5'h01;
        end else if (pop) begin
            stack_pointer_reg_q <= unf ? pcs_pkg::SP_LAST : stack_pointer_reg_q - 5'h01;
        end else if (reg_wr && reg_addr == pcs_pkg::REG_STACK_PTR) begin
            stack_pointer_reg_q <= reg_wdata[4:0];
        end
    end

    logic [3:0] push_slot;
    assign push_slot = ovf ? 4'h0 : 4'(stack_pointer_reg_q + 5'h01);

    always_ff @(posedge sys_clk) begin
        if (push && !stack_reset) begin
            stack_mem[push_slot] <= (ctl.op == pcs_pkg::PCS_OP_INT) ? pc_q : pc_inc;
        end else if (reg_wr && reg_addr == pcs_pkg::REG_TOS_LOW) begin
            stack_mem[stack_pointer_reg_q[3:0]] <= {tos[14:8], reg_wdata};
        end else if (reg_wr && reg_addr == pcs_pkg::REG_TOS_HIGH) begin
            stack_mem[stack_pointer_reg_q[3:0]] <= {reg_wdata[6:0], tos[7:0]};
        end
    end

    // Flags are sticky; software clears, but a new fault wins
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            stack_overflow_flag_q <= 1'b0;
            stack_underflow_flag_q <= 1'b0;
        end else begin
            stack_overflow_flag_q <= ovf || (stack_overflow_flag_q && !(reg_wr
                && reg_addr == pcs_pkg::REG_RESET_STATUS && !reg_wdata[pcs_pkg::RST_OVF_BIT]));
            stack_underflow_flag_q <= unf || (stack_underflow_flag_q && !(reg_wr
                && reg_addr == pcs_pkg::REG_RESET_STATUS && !reg_wdata[pcs_pkg::RST_UNF_BIT]));
        end
    end

    // ----------------------------------------
    // Indirect pointers and decode
    // ----------------------------------------
    logic [15:0] ptr_q [0:1];
    logic [15:0] iaddr;
    logic [15:0] lin_off;
    logic [4:0] lin_bank;
    logic [6:0] lin_byte;
    logic in_trad, in_lin, in_flash, self_ref, lin_ok;
    logic [7:0] ind_rdata_q;
    logic ind_done_q;
    logic pend_q;
    logic ind_req;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_ptr
            always_ff @(posedge sys_clk or negedge resetn) begin
                if (!resetn) begin
                    ptr_q[gi] <= 16'h0000;
                end else if (reg_wr && reg_addr == 4'(pcs_pkg::REG_PTR0_LOW + 4'(2 * gi))) begin
                    ptr_q[gi][7:0] <= reg_wdata;
                end else if (reg_wr && reg_addr == 4'(pcs_pkg::REG_PTR0_HIGH + 4'(2 * gi))) begin
                    ptr_q[gi][15:8] <= reg_wdata;
                end
            end
        end
    endgenerate

    assign iaddr = ptr_q[ind.sel];
    assign in_flash = iaddr[15];
    assign in_trad = !in_flash && iaddr <= pcs_pkg::TRAD_END;
    assign in_lin = !in_flash && iaddr >= pcs_pkg::LIN_BASE && iaddr <= pcs_pkg::LIN_END;
    assign lin_off = iaddr - pcs_pkg::LIN_BASE;
    assign lin_bank = 5'(lin_off / {8'h00, pcs_pkg::GPR_BLOCK});
    assign lin_byte = 7'(lin_off % {8'h00, pcs_pkg::GPR_BLOCK}) + pcs_pkg::GPR_FIRST;
    assign lin_ok = in_lin && 32'(lin_bank) < LIN_BANKS;
    assign self_ref = in_trad && (iaddr[6:0] == pcs_pkg::INDIR0_ADDR
        || iaddr[6:0] == pcs_pkg::INDIR1_ADDR);
    // Request is held through its done cycle; it must not be taken twice
    assign ind_req = ind.valid && !ind_done_q;

    always_comb begin
        mem = '0;
        mem.valid = ind_req && !pend_q && ((in_trad && !self_ref) || lin_ok || (in_flash && !ind.write));
        mem.flash = in_flash;
        mem.write = ind.write && !in_flash;
        mem.wdata = ind.wdata;
        if (in_flash) begin
            mem.addr = iaddr[14:0];
        end else if (in_lin) begin
            mem.addr = {3'b000, lin_bank, lin_byte}; // Bank number above 7-bit offset
        end else begin
            mem.addr = iaddr[14:0];
        end
    end

    // Flash reads take one extra cycle
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pend_q <= 1'b0;
        end else begin
            pend_q <= ind_req && in_flash && !pend_q;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ind_rdata_q <= 8'h00;
            ind_done_q <= 1'b0;
        end else begin
            ind_done_q <= ind_req && (!in_flash || pend_q);
            // Flash byte is taken while addressed; the wait cycle only delays done
            if (ind_req && !ind.write && !pend_q) begin
                if (in_flash) begin
                    ind_rdata_q <= flash_rdata;
                end else if ((in_trad && !self_ref) || lin_ok) begin
                    ind_rdata_q <= mem_rdata;
                end else begin
                    ind_rdata_q <= 8'h00;
                end
            end
        end
    end

    // ----------------------------------------
    // Register read port
    // ----------------------------------------
    logic [7:0] rdata_q;
    logic [7:0] rsel;
    always_comb begin
        unique case (reg_addr)
            pcs_pkg::REG_PC_LOW: rsel = pc_q[7:0];
            pcs_pkg::REG_PC_LATCH: rsel = {1'b0, pc_high_latch_q};
            pcs_pkg::REG_STACK_PTR: rsel = {3'b000, stack_pointer_reg_q};
            pcs_pkg::REG_TOS_LOW: rsel = tos[7:0];
            pcs_pkg::REG_TOS_HIGH: rsel = {1'b0, tos[14:8]};
            pcs_pkg::REG_PTR0_LOW: rsel = ptr_q[0][7:0];
            pcs_pkg::REG_PTR0_HIGH: rsel = ptr_q[0][15:8];
            pcs_pkg::REG_PTR1_LOW: rsel = ptr_q[1][7:0];
            pcs_pkg::REG_PTR1_HIGH: rsel = ptr_q[1][15:8];
            pcs_pkg::REG_RESET_STATUS: rsel = {6'h00, stack_overflow_flag_q, stack_underflow_flag_q};
            default: rsel = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= reg_rd ? rsel : 8'h00;
        end
    end

    assign reg_rdata = rdata_q;
    assign pc = pc_q;
    assign fetch_flush = flush_q;
    assign ind_rdata = ind_rdata_q;
    assign ind_done = ind_done_q;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_pc_low_write: assert property (@(posedge sys_clk) disable iff (!resetn)
        pc_wr && !stack_reset |=> pc_q == {$past(pc_high_latch_q), $past(reg_wdata)})
        else $error("pc low write did not load full pc");
    a_call_load: assert property (@(posedge sys_clk) disable iff (!resetn)
        ctl.op == pcs_pkg::PCS_OP_CALL && !pc_wr && !stack_reset
        |=> pc_q[10:0] == $past(ctl.operand) && pc_q[14:11] == $past(pc_high_latch_q[6:3]))
        else $error("call target wrong");
    a_reg_branch_target: assert property (@(posedge sys_clk) disable iff (!resetn)
        ctl.op == pcs_pkg::PCS_OP_REG_BRANCH && !pc_wr
        |=> pc_q == 15'($past(pc_q) + 15'h0001 + {7'h00, $past(ctl.wreg)}))
        else $error("register branch target wrong");
    a_computed_call_load: assert property (@(posedge sys_clk) disable iff (!resetn)
        ctl.op == pcs_pkg::PCS_OP_COMPUTED_CALL && !pc_wr && !stack_reset
        |=> pc_q == {$past(pc_high_latch_q), $past(ctl.wreg)})
        else $error("computed call target wrong");
    a_imm_branch_target: assert property (@(posedge sys_clk) disable iff (!resetn)
        ctl.op == pcs_pkg::PCS_OP_IMM_BRANCH && !pc_wr
        |=> pc_q == 15'($past(pc_q) + 15'h0001 + {{6{$past(ctl.operand[8])}}, $past(ctl.operand[8:0])}))
        else $error("immediate branch target wrong");
    a_latch_kept: assert property (@(posedge sys_clk) disable iff (!resetn)
        (push || pop) && !(reg_wr && reg_addr == pcs_pkg::REG_PC_LATCH) |=> $stable(pc_high_latch_q))
        else $error("high latch changed by push or pop");
    a_pop_load: assert property (@(posedge sys_clk) disable iff (!resetn)
        pop && !pc_wr && !stack_reset |=> pc_q == $past(tos))
        else $error("return did not load top of stack");
    a_stack_wrap: assert property (@(posedge sys_clk) disable iff (!resetn)
        ovf && !stack_fault_reset_enable |=> stack_pointer_reg_q == 5'h00)
        else $error("overflow did not wrap stack");
    a_push_ptr_inc: assert property (@(posedge sys_clk) disable iff (!resetn)
        push && !ovf && !stack_reset |=> stack_pointer_reg_q == 5'($past(stack_pointer_reg_q) + 5'h01))
        else $error("push did not increment pointer");
    a_ret_pop_dec: assert property (@(posedge sys_clk) disable iff (!resetn)
        pop && stack_pointer_reg_q == 5'h00 |=> stack_pointer_reg_q == pcs_pkg::SP_EMPTY)
        else $error("pop from first entry did not empty stack");
    a_ovf_flag_set: assert property (@(posedge sys_clk) disable iff (!resetn)
        ovf |=> stack_overflow_flag_q)
        else $error("overflow flag not set");
    a_fault_reset: assert property (@(posedge sys_clk) disable iff (!resetn)
        (ovf || unf) && stack_fault_reset_enable |-> stack_reset ##1 pc_q == 15'h0000)
        else $error("stack fault did not reset");
    a_self_ref_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
        ind.valid && !ind.write && self_ref |-> !mem.valid ##1 ind_rdata_q == 8'h00)
        else $error("self-referencing indirect read not zero");
    a_flash_no_write: assert property (@(posedge sys_clk) disable iff (!resetn)
        in_flash |-> !mem.write)
        else $error("flash written through indirect path");
    a_lin_gpr_window: assert property (@(posedge sys_clk) disable iff (!resetn)
        mem.valid && in_lin |-> mem.addr[6:0] >= pcs_pkg::GPR_FIRST
        && mem.addr[6:0] < 7'(pcs_pkg::GPR_FIRST + pcs_pkg::GPR_BLOCK[6:0]))
        else $error("linear access outside general-purpose block");
    a_unmapped_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
        ind_req && !ind.write && !in_trad && !in_lin && !in_flash |=> ind_rdata_q == 8'h00)
        else $error("unmapped indirect read not zero");
    a_flush_on_write: assert property (@(posedge sys_clk) disable iff (!resetn)
        pc_wr |=> fetch_flush)
        else $error("pc low write did not flush fetch");
    sequence s_flash_start;
        ind_req && in_flash && !pend_q;
    endsequence
    a_flash_extra: assert property (@(posedge sys_clk) disable iff (!resetn)
        s_flash_start |=> !ind_done_q ##1 ind_done_q)
        else $error("flash indirect access not two cycles");
endmodule // pcs_core
`default_nettype wire

// file: bench/pcs_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
module pcs_mem_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Access from the block
    input wire pcs_pkg::pcs_mem_s mem,
    output logic [7:0] mem_rdata,
    output logic [7:0] flash_rdata
);
    logic [7:0] noise_q;
    int wr_cnt;
    logic [14:0] last_wa;
    logic [7:0] last_wd;

    // ------------------------------------------------------------
    // Read side
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            noise_q <= 8'h00;
        end else begin
            noise_q <= noise_q + 8'h3B;
        end
    end

    // Idle lines churn, so stale data can never pass for a real answer
    always_comb begin
        mem_rdata = ~noise_q;
        flash_rdata = noise_q;
        if (mem.valid && !mem.flash) begin
            mem_rdata = mem.addr[7:0] ^ {1'b0, mem.addr[14:8]} ^ 8'hA5;
        end
        if (mem.valid && mem.flash) begin
            flash_rdata = mem.addr[7:0] + {1'b0, mem.addr[14:8]} + 8'h11;
        end
    end

    // ------------------------------------------------------------
    // Write side
    // ------------------------------------------------------------
    // Flash takes no writes from this path, only data writes land
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wr_cnt <= 0;
        end else if (mem.valid && mem.write && !mem.flash) begin
            wr_cnt <= wr_cnt + 1;
            last_wa <= mem.addr;
            last_wd <= mem.wdata;
        end
    end
endmodule // pcs_mem_model
`default_nettype wire

// file: bench/pc_stack_indirect_addr_tb.sv
`timescale 1ns/1ns
`default_nettype none
module pc_stack_indirect_addr_tb;
    logic sys_clk;
    logic resetn;
    logic fault_en;
    pcs_pkg::pcs_ctl_s ctl;
    pcs_pkg::pcs_ind_s ind;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    logic [14:0] pc;
    logic fetch_flush;
    logic stack_reset;
    pcs_pkg::pcs_mem_s mem;
    logic [7:0] mem_rdata;
    logic [7:0] flash_rdata;
    logic [7:0] ind_rdata;
    logic ind_done;
    int err_count;
    int compares;
    int cycles;
    int n_data;
    int n_flash;
    int n;
    int wc;
    logic [7:0] rd;
    logic sr_seen;
    logic sr_any;
    logic [15:0] lin_ptr [3] = '{16'h204F, 16'h2050, 16'h29AF};
    logic [14:0] lin_map [3] = '{15'h006F, 15'h00A0, 15'h0F6F};

    pcs_core #(.STACK_DEPTH(16), .LIN_BANKS(32)) dut_u (.sys_clk(sys_clk), .resetn(resetn),
        .stack_fault_reset_enable(fault_en), .ctl(ctl), .ind(ind), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pc(pc),
        .fetch_flush(fetch_flush), .stack_reset(stack_reset), .mem(mem), .mem_rdata(mem_rdata),
        .flash_rdata(flash_rdata), .ind_rdata(ind_rdata), .ind_done(ind_done));
    pcs_mem_model mem_u (.sys_clk(sys_clk), .resetn(resetn), .mem(mem), .mem_rdata(mem_rdata),
        .flash_rdata(flash_rdata));

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    function automatic logic [7:0] dmem(input logic [14:0] a);
        return a[7:0] ^ {1'b0, a[14:8]} ^ 8'hA5;
    endfunction

    function automatic logic [7:0] fmem(input logic [14:0] a);
        return a[7:0] + {1'b0, a[14:8]} + 8'h11;
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // Fault cases pass fl below zero: flush after a fault reset is not defined
    task automatic ev(input pcs_pkg::pcs_op_e o, input logic [10:0] opnd, input logic [7:0] w,
        input logic [14:0] vec, input logic [14:0] exp_pc, input int fl);
        @(posedge sys_clk);
        ctl <= '{op: o, operand: opnd, wreg: w, vector: vec};
        #1 sr_seen = stack_reset;
        sr_any = sr_any | sr_seen;
        @(posedge sys_clk);
        ctl.op <= pcs_pkg::PCS_OP_NONE;
        #1 check(16'(pc), 16'(exp_pc));
        if (fl >= 0) check(16'(fetch_flush), 16'(fl));
    endtask

    task automatic set_ptr(input logic s, input logic [15:0] v);
        reg_write(s ? pcs_pkg::REG_PTR1_LOW : pcs_pkg::REG_PTR0_LOW, v[7:0]);
        reg_write(s ? pcs_pkg::REG_PTR1_HIGH : pcs_pkg::REG_PTR0_HIGH, v[15:8]);
    endtask

    // Request stays up until the edge that sees the done pulse
    task automatic ind_acc(input logic s, input logic w, input logic [7:0] d, output logic [7:0] r,
        output int cnt);
        @(posedge sys_clk);
        ind <= '{valid: 1'b1, sel: s, write: w, wdata: d};
        cnt = 0;
        do begin
            @(posedge sys_clk);
            cnt++;
            #1;
        end while (ind_done !== 1'b1 && cnt < 10);
        r = ind_rdata;
        @(posedge sys_clk);
        ind.valid <= 1'b0;
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        resetn = 1'b0;
        fault_en = 1'b0;
        ctl = '0;
        ind = '0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        err_count = 0;
        compares = 0;
        cycles = 0;
        sr_any = 1'b0;
        repeat (5) @(posedge sys_clk);
        resetn <= 1'b1;
        #1 check(16'(pc), 16'h0000);
        reg_read(pcs_pkg::REG_STACK_PTR, rd);
        check(16'(rd), 16'h001F);
        reg_read(4'hF, rd);
        check(16'(rd), 16'h0000);
        reg_write(pcs_pkg::REG_PC_LATCH, 8'h55);
        reg_write(pcs_pkg::REG_PC_LOW, 8'h34);
        #1 check(16'(pc), 16'h5534);
        check(16'(fetch_flush), 16'h0001);
        reg_read(pcs_pkg::REG_PC_LOW, rd);
        check(16'(rd), 16'h0034);
        ev(pcs_pkg::PCS_OP_CALL, 11'h5A3, 8'h00, 15'h0000, 15'h55A3, 1);
        reg_read(pcs_pkg::REG_STACK_PTR, rd);
        check(16'(rd), 16'h0000);
        reg_read(pcs_pkg::REG_TOS_LOW, rd);
        check(16'(rd), 16'h0035);
        reg_read(pcs_pkg::REG_TOS_HIGH, rd);
        check(16'(rd), 16'h0055);
        reg_read(pcs_pkg::REG_PC_LATCH, rd);
        check(16'(rd), 16'h0055);
        ev(pcs_pkg::PCS_OP_COMPUTED_CALL, 11'h000, 8'h77, 15'h0000, 15'h5577, 1);
        ev(pcs_pkg::PCS_OP_REG_BRANCH, 11'h000, 8'hF0, 15'h0000, 15'h5668, 1);
        ev(pcs_pkg::PCS_OP_IMM_BRANCH, 11'h1F0, 8'h00, 15'h0000, 15'h5659, 1);
        ev(pcs_pkg::PCS_OP_INT, 11'h000, 8'h00, 15'h0004, 15'h0004, 0);
        ev(pcs_pkg::PCS_OP_RET, 11'h000, 8'h00, 15'h0000, 15'h5659, 1);
        ev(pcs_pkg::PCS_OP_RET, 11'h000, 8'h00, 15'h0000, 15'h55A4, 1);
        ev(pcs_pkg::PCS_OP_RET, 11'h000, 8'h00, 15'h0000, 15'h5535, 1);
        reg_read(pcs_pkg::REG_STACK_PTR, rd);
        check(16'(rd), 16'h001F);
        reg_write(pcs_pkg::REG_PC_LATCH, 8'h00);
        for (int i = 0; i < 17; i++) begin
            ev(pcs_pkg::PCS_OP_CALL, 11'h100 + 11'(i), 8'h00, 15'h0000, 15'h0100 + 15'(i), 1);
            if (i == 15) begin
                reg_read(pcs_pkg::REG_STACK_PTR, rd);
                check(16'(rd), 16'h000F);
            end
        end
        reg_read(pcs_pkg::REG_RESET_STATUS, rd);
        check(16'(rd[pcs_pkg::RST_OVF_BIT]), 16'h0001);
        check(16'(sr_any), 16'h0000);
        reg_write(pcs_pkg::REG_STACK_PTR, 8'h00);
        reg_read(pcs_pkg::REG_TOS_LOW, rd);
        check(16'(rd), 16'h0010);
        reg_read(pcs_pkg::REG_TOS_HIGH, rd);
        check(16'(rd), 16'h0001);
        reg_write(pcs_pkg::REG_TOS_LOW, 8'hAB);
        reg_write(pcs_pkg::REG_TOS_HIGH, 8'h12);
        ev(pcs_pkg::PCS_OP_RET, 11'h000, 8'h00, 15'h0000, 15'h12AB, 1);
        reg_write(pcs_pkg::REG_RESET_STATUS, 8'h00);
        fault_en <= 1'b1;
        ev(pcs_pkg::PCS_OP_RET, 11'h000, 8'h00, 15'h0000, 15'h0000, -1);
        check(16'(sr_seen), 16'h0001);
        reg_read(pcs_pkg::REG_RESET_STATUS, rd);
        check(16'(rd[pcs_pkg::RST_UNF_BIT]), 16'h0001);
        reg_read(pcs_pkg::REG_STACK_PTR, rd);
        check(16'(rd), 16'h001F);
        reg_write(pcs_pkg::REG_STACK_PTR, 8'h0F);
        ev(pcs_pkg::PCS_OP_CALL, 11'h001, 8'h00, 15'h0000, 15'h0000, -1);
        check(16'(sr_seen), 16'h0001);
        reg_read(pcs_pkg::REG_RESET_STATUS, rd);
        check(16'(rd[pcs_pkg::RST_OVF_BIT]), 16'h0001);
        fault_en <= 1'b0;
        set_ptr(1'b0, 16'h0123);
        ind_acc(1'b0, 1'b0, 8'h00, rd, n_data);
        check(16'(rd), 16'(dmem(15'h0123)));
        set_ptr(1'b1, 16'h20F5);
        reg_read(pcs_pkg::REG_PTR1_HIGH, rd);
        check(16'(rd), 16'h0020);
        wc = mem_u.wr_cnt;
        ind_acc(1'b1, 1'b1, 8'h5C, rd, n);
        check(16'(mem_u.wr_cnt - wc), 16'h0001);
        check(16'(mem_u.last_wa), 16'h01A5);
        check(16'(mem_u.last_wd), 16'h005C);
        for (int k = 0; k < 3; k++) begin
            set_ptr(1'b1, lin_ptr[k]);
            ind_acc(1'b1, 1'b0, 8'h00, rd, n);
            check(16'(rd), 16'(dmem(lin_map[k])));
        end
        set_ptr(1'b1, 16'h29B0);
        ind_acc(1'b1, 1'b0, 8'h00, rd, n);
        check(16'(rd), 16'h0000);
        set_ptr(1'b0, 16'h8123);
        ind_acc(1'b0, 1'b0, 8'h00, rd, n_flash);
        check(16'(rd), 16'(fmem(15'h0123)));
        check(16'(n_flash), 16'(n_data + 1));
        wc = mem_u.wr_cnt;
        ind_acc(1'b0, 1'b1, 8'h99, rd, n);
        check(16'(mem_u.wr_cnt - wc), 16'h0000);
        set_ptr(1'b0, 16'h0080);
        ind_acc(1'b0, 1'b0, 8'h00, rd, n);
        check(16'(rd), 16'h0000);
        ind_acc(1'b0, 1'b1, 8'h66, rd, n);
        check(16'(mem_u.wr_cnt - wc), 16'h0000);
        print_verdict();
    end
endmodule // pc_stack_indirect_addr_tb
`default_nettype wire
